// ### rtl/dlio_top.sv
// Implementation choices: the plain strobed port and the register addresses.
`include "dlio_map.svh"
`default_nettype none
module dlio_top (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [3:0]  line_in,
  output wire logic [3:0]  line_out,
  output wire logic [3:0]  line_oe,
  output wire logic [3:0]  aux_supply_enable,
  input  wire logic        counter_zero_running,
  input  wire logic        counter_one_running,
  input  wire logic        logic_unit_zero_out,
  input  wire logic        logic_unit_one_out,
  input  wire logic        expo_line_based,
  input  wire logic        expo_any_pixel,
  input  wire logic        expo_every_pixel,
  input  wire logic        trigger_accept_ready,
  input  wire logic        pulse_per_second,
  input  wire logic        serial_tx_source,
  output logic             serial_rx_line,
  output logic      [3:0]  serial_baud_sel,
  output logic      [3:0]  serial_data_bits,
  output logic      [1:0]  serial_stop_sel,
  output logic      [2:0]  serial_parity_sel,
  input  wire logic        rx_char_valid,
  input  wire logic [8:0]  rx_char,
  input  wire logic        rx_frame_err,
  input  wire logic        rx_parity_err,
  output logic             rx_data_event,
  output logic             rx_overflow
);

  localparam logic [7:0] KINDS   = `DLIO_LINE_KINDS;
  localparam logic [3:0] AUX_CAP = `DLIO_AUX_CAPABLE;

  logic [1:0]                 line_sel_q;
  logic                       dir_q   [0:3];
  logic                       inv_q   [0:3];
  logic                       aux_q   [0:3];
  dlio_pkg::dlio_src_e        src_q   [0:3];
  dlio_pkg::dlio_ftype_e      ftype_q;
  logic [15:0]                fw_q    [0:3][0:1];
  dlio_pkg::dlio_form_e       form_q;
  logic [1:0]                 soft_output_index;
  logic [3:0]                 soft_output_word;
  logic [2:0]                 rx_sel_q;
  logic [3:0]                 lvl_w;
  logic                       expo_q;
  logic [8:0]                 rxq_mem [0:15];
  logic [`DLIO_RXQ_AW-1:0]    wp_q;
  logic [`DLIO_RXQ_AW-1:0]    rp_q;
  logic [4:0]                 cnt_q;
  logic [15:0]                ferr_q;
  logic [15:0]                perr_q;
  logic [31:0]                rd_d;
  logic                       wr_en;
  logic                       rd_en;
  logic                       flush;
  logic                       push;
  logic                       pop;
  logic                       full;

  // Qualified bus strokes
  assign wr_en = ce && reg_wr;
  assign rd_en = ce && reg_rd;
  assign flush = wr_en && (reg_addr == `DLIO_OFS_RX_FLUSH) && reg_wdata[0];
  assign full  = (cnt_q == `DLIO_RXQ_DEPTH);
  assign push  = rx_char_valid && !full && !flush;
  assign pop   = rd_en && (reg_addr == `DLIO_OFS_RX_DATA) &&
                 (cnt_q != 5'h0) && !flush;

  // Software configuration registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      line_sel_q        <= 2'h0;
      ftype_q           <= dlio_pkg::deglitch_type;
      form_q            <= dlio_pkg::line_based_exposing;
      soft_output_index <= 2'h0;
      soft_output_word  <= 4'h0;
      rx_sel_q          <= `DLIO_RST_RX_SEL;
      serial_baud_sel   <= `DLIO_RST_BAUD;
      serial_data_bits  <= `DLIO_RST_DBITS;
      serial_stop_sel   <= 2'h0;
      serial_parity_sel <= 3'h0;
      for (int k = 0; k < `DLIO_NUM_LINES; k++)
      begin
        dir_q[k]    <= 1'h0;
        inv_q[k]    <= 1'h0;
        aux_q[k]    <= 1'h0;
        src_q[k]    <= dlio_pkg::src_off;
        fw_q[k][0]  <= 16'h0;
        fw_q[k][1]  <= 16'h0;
      end
    end
    else if (wr_en)
    begin
      if (reg_addr == `DLIO_OFS_LINE_SEL)
        line_sel_q <= reg_wdata[1:0];
      else if (reg_addr == `DLIO_OFS_LINE_CFG)
      begin
        dir_q[line_sel_q] <= reg_wdata[`DLIO_CFG_DIR];
        inv_q[line_sel_q] <= reg_wdata[`DLIO_CFG_INV];
        aux_q[line_sel_q] <= reg_wdata[`DLIO_CFG_AUX] &
                             AUX_CAP[line_sel_q];
        if (reg_wdata[`DLIO_CFG_SRC_LSB +: 5] <= `DLIO_MAX_SRC)
          src_q[line_sel_q] <= dlio_pkg::dlio_src_e'(
                                 reg_wdata[`DLIO_CFG_SRC_LSB +: 5]);
      end
      else if (reg_addr == `DLIO_OFS_FILT_SEL)
        ftype_q <= dlio_pkg::dlio_ftype_e'(reg_wdata[0]);
      else if (reg_addr == `DLIO_OFS_FILT_WIDTH)
        fw_q[line_sel_q][ftype_q] <= reg_wdata[15:0];
      else if (reg_addr == `DLIO_OFS_EXPO_FORM)
      begin
        if (reg_wdata[1:0] != 2'h3)
          form_q <= dlio_pkg::dlio_form_e'(reg_wdata[1:0]);
      end
      else if (reg_addr == `DLIO_OFS_SOFT_IDX)
        soft_output_index <= reg_wdata[1:0];
      else if (reg_addr == `DLIO_OFS_SOFT_BIT)
        soft_output_word[soft_output_index] <= reg_wdata[0];
      else if (reg_addr == `DLIO_OFS_SOFT_WORD)
        soft_output_word <= reg_wdata[3:0];
      else if (reg_addr == `DLIO_OFS_RX_LINE_SEL)
      begin
        if (reg_wdata[2:0] <= `DLIO_RX_LINE_OFF)
          rx_sel_q <= reg_wdata[2:0];
      end
      else if (reg_addr == `DLIO_OFS_SERIAL_CFG)
      begin
        // One setting set serves receive and transmit
        if (reg_wdata[`DLIO_SCFG_BAUD_LSB +: 4] <= `DLIO_MAX_BAUD)
          serial_baud_sel <= reg_wdata[`DLIO_SCFG_BAUD_LSB +: 4];
        if (reg_wdata[`DLIO_SCFG_DBITS_LSB +: 4] >= `DLIO_MIN_DBITS &&
            reg_wdata[`DLIO_SCFG_DBITS_LSB +: 4] <= `DLIO_MAX_DBITS)
          serial_data_bits <= reg_wdata[`DLIO_SCFG_DBITS_LSB +: 4];
        serial_stop_sel <= reg_wdata[`DLIO_SCFG_STOP_LSB +: 2];
        if (reg_wdata[`DLIO_SCFG_PAR_LSB +: 3] <= `DLIO_MAX_PAR)
          serial_parity_sel <= reg_wdata[`DLIO_SCFG_PAR_LSB +: 3];
      end
    end
  end

  // Exposure signal formed per the chosen form
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      expo_q <= 1'h0;
    else if (ce)
    begin
      case (form_q)
        dlio_pkg::any_pixel_exposing:   expo_q <= expo_any_pixel;
        dlio_pkg::every_pixel_exposing: expo_q <= expo_every_pixel;
        default:                        expo_q <= expo_line_based;
      endcase
    end
  end

  // Per-line filter, source mux and pin drive
  for (genvar i = 0; i < `DLIO_NUM_LINES; i++)
  begin : g_line
    dlio_filt_if fif ();
    logic drv;
    logic val;
    logic pin_q;
    logic oe_q;
    logic lvl_q;
    logic auxo_q;

    assign fif.raw        = line_in[i];
    assign fif.glitch_cyc = 23'(fw_q[i][0]) * 23'(`DLIO_CYC_PER_US);
    assign fif.bounce_cyc = 23'(fw_q[i][1]) * 23'(`DLIO_CYC_PER_US);

    dlio_filter u_filt (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ce      (ce),
      .fp      (fif)
    );

    // Source multiplexer
    always_comb
    begin
      case (src_q[i])
        dlio_pkg::src_line0:     drv = lvl_w[0];
        dlio_pkg::src_line1:     drv = lvl_w[1];
        dlio_pkg::src_line2:     drv = lvl_w[2];
        dlio_pkg::src_line3:     drv = lvl_w[3];
        dlio_pkg::src_soft0:     drv = soft_output_word[0];
        dlio_pkg::src_soft1:     drv = soft_output_word[1];
        dlio_pkg::src_soft2:     drv = soft_output_word[2];
        dlio_pkg::src_soft3:     drv = soft_output_word[3];
        dlio_pkg::src_cnt0:      drv = counter_zero_running;
        dlio_pkg::src_cnt1:      drv = counter_one_running;
        dlio_pkg::src_logic0:    drv = logic_unit_zero_out;
        dlio_pkg::src_logic1:    drv = logic_unit_one_out;
        dlio_pkg::src_expo:      drv = expo_q;
        dlio_pkg::src_trig_wait: drv = trigger_accept_ready;
        dlio_pkg::src_pps:       drv = pulse_per_second;
        dlio_pkg::src_serial_tx: drv = serial_tx_source;
        default:                 drv = 1'h0;
      endcase
      val = drv ^ inv_q[i];
    end

    // Pin drive and logical level
    always_ff @(posedge clk_sys)
    begin
      if (rst)
      begin
        pin_q  <= 1'h0;
        oe_q   <= 1'h0;
        lvl_q  <= 1'h0;
        auxo_q <= 1'h0;
      end
      else if (ce)
      begin
        auxo_q <= aux_q[i];
        if (dir_q[i])
        begin
          lvl_q <= val;
          if (KINDS[2*i +: 2] == dlio_pkg::pull_low_kind)
          begin
            pin_q <= 1'h0; // Can only pull low, high by pull-up
            oe_q  <= ~val;
          end
          else
          begin
            pin_q <= val;
            oe_q  <= 1'h1;
          end
        end
        else
        begin
          pin_q <= 1'h0;
          oe_q  <= 1'h0;
          lvl_q <= fif.filt ^ inv_q[i];
        end
      end
    end

    assign line_out[i]          = pin_q;
    assign line_oe[i]           = oe_q;
    assign aux_supply_enable[i] = auxo_q;
    assign lvl_w[i]             = lvl_q;
  end

  // Serial receive line taken from the chosen line, idle when off
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      serial_rx_line <= `DLIO_RX_IDLE;
    else if (ce)
    begin
      if (rx_sel_q == `DLIO_RX_LINE_OFF)
        serial_rx_line <= `DLIO_RX_IDLE;
      else
        serial_rx_line <= lvl_w[rx_sel_q[1:0]];
    end
  end

  // Receive queue storage
  always_ff @(posedge clk_sys)
  begin
    if (ce && push)
      rxq_mem[wp_q] <= rx_char;
  end

  // Receive queue pointers; flush discards all held characters
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= 5'h0;
    end
    else if (ce)
    begin
      if (flush)
      begin
        wp_q  <= '0;
        rp_q  <= '0;
        cnt_q <= 5'h0;
      end
      else
      begin
        if (push)
          wp_q <= wp_q + 1'h1;
        if (pop)
          rp_q <= rp_q + 1'h1;
        cnt_q <= cnt_q + 5'(push) - 5'(pop);
      end
    end
  end

  // Overflow flag, arrival event; a new overflow wins over a clear
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rx_overflow   <= 1'h0;
      rx_data_event <= 1'h0;
    end
    else if (ce)
    begin
      rx_data_event <= push;
      if (rx_char_valid && full)
        rx_overflow <= 1'h1;
      else if (flush ||
               (rd_en && reg_addr == `DLIO_OFS_RX_DATA))
        rx_overflow <= 1'h0;
    end
  end

  // Error counters
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ferr_q <= 16'h0;
      perr_q <= 16'h0;
    end
    else if (ce)
    begin
      if (rx_frame_err)
        ferr_q <= ferr_q + 16'h1;
      if (rx_parity_err)
        perr_q <= perr_q + 16'h1;
    end
  end

  // Read decode
  always_comb
  begin
    rd_d = 32'h0;
    if (reg_addr == `DLIO_OFS_LINE_SEL)
      rd_d = {30'h0, line_sel_q};
    else if (reg_addr == `DLIO_OFS_LINE_CFG)
      rd_d = {18'h0, KINDS[2*line_sel_q +: 2], 3'h0, src_q[line_sel_q],
              1'h0, aux_q[line_sel_q], inv_q[line_sel_q],
              dir_q[line_sel_q]};
    else if (reg_addr == `DLIO_OFS_LINE_LEVEL)
      rd_d = {31'h0, lvl_w[line_sel_q]};
    else if (reg_addr == `DLIO_OFS_ALL_LEVELS)
      rd_d = {28'h0, lvl_w};
    else if (reg_addr == `DLIO_OFS_FILT_SEL)
      rd_d = {31'h0, ftype_q};
    else if (reg_addr == `DLIO_OFS_FILT_WIDTH)
      rd_d = {16'h0, fw_q[line_sel_q][ftype_q]};
    else if (reg_addr == `DLIO_OFS_EXPO_FORM)
      rd_d = {30'h0, form_q};
    else if (reg_addr == `DLIO_OFS_SOFT_IDX)
      rd_d = {30'h0, soft_output_index};
    else if (reg_addr == `DLIO_OFS_SOFT_BIT)
      rd_d = {31'h0, soft_output_word[soft_output_index]};
    else if (reg_addr == `DLIO_OFS_SOFT_WORD)
      rd_d = {28'h0, soft_output_word};
    else if (reg_addr == `DLIO_OFS_RX_LINE_SEL)
      rd_d = {29'h0, rx_sel_q};
    else if (reg_addr == `DLIO_OFS_SERIAL_CFG)
      rd_d = {19'h0, serial_parity_sel, serial_stop_sel,
              serial_data_bits, serial_baud_sel};
    else if (reg_addr == `DLIO_OFS_FRAME_ERRS)
      rd_d = {16'h0, ferr_q};
    else if (reg_addr == `DLIO_OFS_PARITY_ERRS)
      rd_d = {16'h0, perr_q};
    else if (reg_addr == `DLIO_OFS_RX_DATA)
      rd_d = {14'h0, rx_overflow, cnt_q != 5'h0, 7'h0,
              rxq_mem[rp_q]};
    else if (reg_addr == `DLIO_OFS_RX_STATUS)
      rd_d = {11'h0, `DLIO_RXQ_DEPTH, 7'h0, rx_overflow, 3'h0, cnt_q};
  end

  // Read data held for one cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      reg_rdata <= 32'h0;
    else if (ce)
      reg_rdata <= rd_en ? rd_d : 32'h0;
  end

endmodule : dlio_top
`default_nettype wire

// ### rtl/dlio_map.svh
`ifndef DLIO_MAP_SVH
`define DLIO_MAP_SVH

// Line count and clock timing
`define DLIO_NUM_LINES        4
`define DLIO_CLK_PERIOD_NS    8
`define DLIO_NS_PER_US        1000
`define DLIO_CYC_PER_US       (`DLIO_NS_PER_US / `DLIO_CLK_PERIOD_NS)

// Register byte offsets
`define DLIO_OFS_LINE_SEL     8'h00
`define DLIO_OFS_LINE_CFG     8'h04
`define DLIO_OFS_LINE_LEVEL   8'h08
`define DLIO_OFS_ALL_LEVELS   8'h0C
`define DLIO_OFS_FILT_SEL     8'h10
`define DLIO_OFS_FILT_WIDTH   8'h14
`define DLIO_OFS_EXPO_FORM    8'h18
`define DLIO_OFS_SOFT_IDX     8'h1C
`define DLIO_OFS_SOFT_BIT     8'h20
`define DLIO_OFS_SOFT_WORD    8'h24
`define DLIO_OFS_RX_LINE_SEL  8'h28
`define DLIO_OFS_SERIAL_CFG   8'h2C
`define DLIO_OFS_RX_FLUSH     8'h30
`define DLIO_OFS_FRAME_ERRS   8'h34
`define DLIO_OFS_PARITY_ERRS  8'h38
`define DLIO_OFS_RX_DATA      8'h3C
`define DLIO_OFS_RX_STATUS    8'h40

// Line configuration field positions
`define DLIO_CFG_DIR          0
`define DLIO_CFG_INV          1
`define DLIO_CFG_AUX          2
`define DLIO_CFG_SRC_LSB      4
`define DLIO_CFG_KIND_LSB     12

// Serial configuration field positions
`define DLIO_SCFG_BAUD_LSB    0
`define DLIO_SCFG_DBITS_LSB   4
`define DLIO_SCFG_STOP_LSB    8
`define DLIO_SCFG_PAR_LSB     10

// Reset values and limits
`define DLIO_RST_RX_SEL       3'h4
`define DLIO_RST_BAUD         4'h5
`define DLIO_RST_DBITS        4'h8
`define DLIO_MIN_DBITS        4'h5
`define DLIO_MAX_DBITS        4'h9
`define DLIO_MAX_SRC          5'h10
`define DLIO_MAX_BAUD         4'hA
`define DLIO_MAX_PAR          3'h4
`define DLIO_RX_LINE_OFF      3'h4
`define DLIO_RX_IDLE          1'h1

// Fixed line properties, two kind bits per line, line 0 lowest
`define DLIO_LINE_KINDS       8'h09
`define DLIO_AUX_CAPABLE      4'h8

// Receive queue shape
`define DLIO_RXQ_DEPTH        5'h10
`define DLIO_RXQ_AW           4

`endif

// ### rtl/dlio_pkg.sv
`default_nettype none
package dlio_pkg;

  // Output source choices of a line
  typedef enum logic [4:0] {
    src_off       = 5'h00,
    src_line0     = 5'h01,
    src_line1     = 5'h02,
    src_line2     = 5'h03,
    src_line3     = 5'h04,
    src_soft0     = 5'h05,
    src_soft1     = 5'h06,
    src_soft2     = 5'h07,
    src_soft3     = 5'h08,
    src_cnt0      = 5'h09,
    src_cnt1      = 5'h0A,
    src_logic0    = 5'h0B,
    src_logic1    = 5'h0C,
    src_expo      = 5'h0D,
    src_trig_wait = 5'h0E,
    src_pps       = 5'h0F,
    src_serial_tx = 5'h10
  } dlio_src_e;

  // Electrical kind of a line
  typedef enum logic [1:0] {
    undriven_kind = 2'h0,
    isolated_kind = 2'h1,
    pull_low_kind = 2'h2
  } dlio_kind_e;

  // How the exposure signal is formed
  typedef enum logic [1:0] {
    line_based_exposing  = 2'h0,
    any_pixel_exposing   = 2'h1,
    every_pixel_exposing = 2'h2
  } dlio_form_e;

  // Input filter type addressed by the width access
  typedef enum logic {
    deglitch_type = 1'h0,
    debounce_type = 1'h1
  } dlio_ftype_e;

endpackage : dlio_pkg
`default_nettype wire

// ### rtl/dlio_filt_if.sv
`default_nettype none
interface dlio_filt_if;
  logic        raw;
  logic        filt;
  logic [22:0] glitch_cyc;
  logic [22:0] bounce_cyc;

  modport flt (input raw, input glitch_cyc, input bounce_cyc, output filt);
  modport ctl (output raw, output glitch_cyc, output bounce_cyc,
               input filt);
endinterface : dlio_filt_if
`default_nettype wire

// ### rtl/dlio_filter.sv
`default_nettype none
module dlio_filter (
  input  wire logic    clk_sys,
  input  wire logic    rst,
  input  wire logic    ce,
  dlio_filt_if.flt     fp
);

  logic        glitch_q;
  logic        bounce_q;
  logic [22:0] gcnt_q;
  logic [22:0] bcnt_q;

  assign fp.filt = bounce_q;

  // Deglitch: integrating count, short pulses bleed away
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      glitch_q <= 1'h0;
      gcnt_q   <= 23'h0;
    end
    else if (ce)
    begin
      if (fp.raw != glitch_q)
      begin
        if (gcnt_q + 23'h1 >= fp.glitch_cyc)
        begin
          glitch_q <= fp.raw;
          gcnt_q   <= 23'h0;
        end
        else
          gcnt_q <= gcnt_q + 23'h1;
      end
      else if (gcnt_q != 23'h0)
        gcnt_q <= gcnt_q - 23'h1;
    end
  end

  // Debounce: any bounce restarts the stability count
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      bounce_q <= 1'h0;
      bcnt_q   <= 23'h0;
    end
    else if (ce)
    begin
      if (glitch_q != bounce_q)
      begin
        if (bcnt_q + 23'h1 >= fp.bounce_cyc)
        begin
          bounce_q <= glitch_q;
          bcnt_q   <= 23'h0;
        end
        else
          bcnt_q <= bcnt_q + 23'h1;
      end
      else
        bcnt_q <= 23'h0;
    end
  end

endmodule : dlio_filter
`default_nettype wire

// ### verification/dlio_assertions.sv
`default_nettype none
module dlio_assertions (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_rdata,
  input  wire logic [3:0]  line_out,
  input  wire logic [3:0]  aux_supply_enable,
  input  wire logic        serial_rx_line,
  input  wire logic [3:0]  serial_baud_sel,
  input  wire logic [3:0]  serial_data_bits,
  input  wire logic [2:0]  serial_parity_sel,
  input  wire logic        rx_char_valid,
  input  wire logic        rx_data_event,
  input  wire logic        rx_overflow
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain for every check
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Register read port
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  a_unmapped_read_zero: assert property ($past(reg_rd) &&
    $past(reg_addr) > 8'h40 |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_queue_depth_field: assert property ($past(reg_rd) &&
    $past(reg_addr) == 8'h40 |-> reg_rdata[20:16] == 5'h10 &&
    reg_rdata[4:0] <= 5'h10)
    else $error("queue status field wrong");
  // Serial receive side
  a_event_has_char: assert property (rx_data_event |->
    $past(rx_char_valid))
    else $error("event without character");
  a_overflow_cause: assert property ($rose(rx_overflow) |->
    $past(rx_char_valid))
    else $error("overflow without character");
  a_serial_cfg_legal: assert property (serial_baud_sel <= 4'hA &&
    serial_data_bits inside {[4'h5:4'h9]} && serial_parity_sel <= 3'h4)
    else $error("serial setting out of range");
  a_reset_levels: assert property ($past(rst) |-> serial_rx_line &&
    serial_baud_sel == 4'h5 && serial_data_bits == 4'h8)
    else $error("reset level wrong");
  // Fixed line properties
  a_pull_low_line: assert property (line_out[1] == 1'b0)
    else $error("pull-low line driven high");
  a_aux_capable_only: assert property (
    aux_supply_enable[2:0] == 3'h0)
    else $error("aux supply on non-capable line");

  // Main scenarios reached
  c_event: cover property (rx_data_event);
  c_overflow: cover property ($rose(rx_overflow));
  c_aux_on: cover property (aux_supply_enable[3]);
endmodule : dlio_assertions
`default_nettype wire

// ### verification/dlio_ext_model.sv
`default_nettype none
module dlio_ext_model (
  input  wire logic [3:0] line_out,
  input  wire logic [3:0] line_oe,
  input  wire logic [3:0] ext_level,
  output wire logic [3:0] line_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wire level: device drive wins, else the equipment level
  assign line_in = (line_oe & line_out) |
                   (~line_oe & ext_level);
endmodule : dlio_ext_model
`default_nettype wire

// ### verification/dlio_top_test.sv
`default_nettype none
module dlio_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clk_sys = 1'b0;
  logic            rst = 1'b1;
  logic [7:0]      reg_addr = 8'h00;
  logic [31:0]     reg_wdata = 32'h0;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  logic [9:0]      src = 10'h000;
  logic [3:0]      lvl = 4'h0;
  logic            rx_char_valid = 1'b0;
  logic [8:0]      rx_char = 9'h000;
  logic            rx_frame_err = 1'b0;
  logic            rx_parity_err = 1'b0;
  wire logic [31:0] reg_rdata;
  wire logic [3:0] line_in, line_out, line_oe, aux_supply_enable;
  wire logic [3:0] serial_baud_sel, serial_data_bits;
  wire logic [1:0] serial_stop_sel;
  wire logic [2:0] serial_parity_sel;
  wire logic       serial_rx_line, rx_data_event, rx_overflow;
  int              n_errors = 0;
  int              samples_checked = 0;
  int              i;

  // Device and external equipment
  dlio_top i_dut (.clk_sys, .rst, .ce(1'b1), .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .line_in, .line_out, .line_oe,
    .aux_supply_enable, .counter_zero_running(src[0]),
    .counter_one_running(src[1]), .logic_unit_zero_out(src[2]),
    .logic_unit_one_out(src[3]), .expo_line_based(src[4]),
    .expo_any_pixel(src[5]), .expo_every_pixel(src[6]),
    .trigger_accept_ready(src[7]), .pulse_per_second(src[8]),
    .serial_tx_source(src[9]), .serial_rx_line, .serial_baud_sel,
    .serial_data_bits, .serial_stop_sel, .serial_parity_sel,
    .rx_char_valid, .rx_char, .rx_frame_err, .rx_parity_err,
    .rx_data_event, .rx_overflow);
  dlio_ext_model i_ext (.line_out, .line_oe, .ext_level(lvl), .line_in);

  // Clock
  always #4 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      n_errors++;
      $display("MISMATCH %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rc

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic push(input logic [8:0] c, input logic e);
    @(posedge clk_sys);
    rx_char       <= c;
    rx_char_valid <= 1'b1;
    @(posedge clk_sys);
    rx_char_valid <= 1'b0;
    #1;
    chk(rx_data_event, e);
  endtask : push

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // Watchdog
  initial
  begin
    #100000;
    n_errors++;
    stop_test;
  end

  // Test sequence
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(1);
    chk(serial_rx_line, 1'b1);
    rc(8'h2C, 32'h85);
    rc(8'h44, 32'h0);
    for (i = 0; i < 4; i++)
    begin
      wr(8'h00, i);
      rc(8'h04, i == 0 ? 32'h1000 : i == 1 ? 32'h2000 : 32'h0);
    end
    wr(8'h04, 32'h4);
    cyc(2);
    chk(aux_supply_enable, 4'h8);
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h4);
    rc(8'h04, 32'h0);
    // Pull-low line only sinks: enable high while the value is low
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h51);
    cyc(2);
    chk({line_oe[1], line_out[1]}, 2'h2);
    wr(8'h04, 32'h53);
    cyc(2);
    chk({line_oe[1], line_out[1]}, 2'h0);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h2);
    $display("test lines done");
    wr(8'h24, 32'h5);
    rc(8'h24, 32'h5);
    wr(8'h1C, 32'h1);
    wr(8'h20, 32'h1);
    rc(8'h24, 32'h7);
    wr(8'h1C, 32'h2);
    rc(8'h20, 32'h1);
    wr(8'h20, 32'h0);
    rc(8'h24, 32'h3);
    for (i = 5; i < 9; i++)
    begin
      wr(8'h04, 32'h1 | (i << 4));
      cyc(3);
      chk({line_oe[2], line_out[2]}, {1'b1, i < 7});
    end
    @(posedge clk_sys) lvl <= 4'h1;
    wr(8'h04, 32'h11);
    cyc(6);
    chk(line_out[2], 1'b1);
    wr(8'h04, 32'h13);
    cyc(3);
    chk(line_out[2], 1'b0);
    for (i = 9; i < 17; i++)
    begin
      @(posedge clk_sys)
        src <= 10'h1 << (i < 13 ? i - 9 : i == 13 ? 4 : i - 7);
      wr(8'h04, 32'h1 | (i << 4));
      cyc(4);
      chk(line_out[2], 1'b1);
      @(posedge clk_sys) src <= ~src;
      cyc(4);
      chk(line_out[2], 1'b0);
    end
    wr(8'h18, 32'h1);
    @(posedge clk_sys) src <= 10'h20;
    wr(8'h04, 32'hD1);
    cyc(4);
    chk(line_out[2], 1'b1);
    wr(8'h18, 32'h3);
    rc(8'h18, 32'h1);
    $display("test sources done");
    @(posedge clk_sys) lvl <= 4'h6;
    wr(8'h04, 32'hD0);
    cyc(5);
    chk(line_oe[2], 1'b0);
    rc(8'h08, 32'h1);
    rc(8'h0C, 32'h6);
    wr(8'h04, 32'hD2);
    cyc(5);
    rc(8'h0C, 32'h2);
    wr(8'h04, 32'h0);
    wr(8'h28, 32'h2);
    @(posedge clk_sys) lvl <= 4'h2;
    cyc(5);
    chk(serial_rx_line, 1'b0);
    wr(8'h28, 32'h4);
    cyc(2);
    chk(serial_rx_line, 1'b1);
    wr(8'h2C, 32'h977);
    cyc(1);
    chk({serial_parity_sel, serial_stop_sel, serial_data_bits,
         serial_baud_sel}, 32'h977);
    wr(8'h2C, 32'h97B);
    rc(8'h2C, 32'h977);
    wr(8'h00, 32'h0);
    wr(8'h14, 32'h1);
    rc(8'h14, 32'h1);
    @(posedge clk_sys) lvl <= 4'h3;
    cyc(60);
    @(posedge clk_sys) lvl <= 4'h2;
    cyc(80);
    rc(8'h08, 32'h0);
    @(posedge clk_sys) lvl <= 4'h3;
    cyc(100);
    rc(8'h08, 32'h0);
    cyc(40);
    rc(8'h08, 32'h1);
    wr(8'h10, 32'h1);
    rc(8'h14, 32'h0);
    // Debounce 1 us, deglitch off: a short return restarts the count
    wr(8'h14, 32'h1);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h0);
    rc(8'h14, 32'h0);
    @(posedge clk_sys) lvl <= 4'h2;
    cyc(100);
    @(posedge clk_sys) lvl <= 4'h3;
    cyc(10);
    @(posedge clk_sys) lvl <= 4'h2;
    cyc(100);
    rc(8'h08, 32'h1);
    cyc(40);
    rc(8'h08, 32'h0);
    $display("test inputs done");
    push(9'h1A5, 1'b1);
    push(9'h0C3, 1'b1);
    rc(8'h40, 32'h100002);
    rc(8'h3C, 32'h101A5);
    wr(8'h30, 32'h1);
    rc(8'h40, 32'h100000);
    for (i = 0; i < 17; i++)
      push(i, i < 16);
    chk(rx_overflow, 1'b1);
    rc(8'h40, 32'h100110);
    rc(8'h3C, 32'h30000);
    chk(rx_overflow, 1'b0);
    for (i = 0; i < 3; i++)
    begin
      @(posedge clk_sys);
      rx_frame_err  <= i < 2;
      rx_parity_err <= i == 0;
      @(posedge clk_sys);
      rx_frame_err  <= 1'b0;
      rx_parity_err <= 1'b0;
    end
    rc(8'h34, 32'h2);
    rc(8'h38, 32'h1);
    $display("test serial done");
    stop_test;
  end
endmodule : dlio_top_test

bind dlio_top dlio_assertions i_chk (.clk_sys, .rst, .reg_addr, .reg_rd,
  .reg_rdata, .line_out, .aux_supply_enable, .serial_rx_line,
  .serial_baud_sel, .serial_data_bits, .serial_parity_sel,
  .rx_char_valid, .rx_data_event, .rx_overflow);
`default_nettype wire
